// file: rtl/edac_codec.sv
// SEC-DED Hamming encoder and decoder for one 32-bit data word.
// Assumes purely combinational use; the caller registers whatever it needs.
`timescale 1ns/1ps
module edac_codec #(
  parameter int unsigned DW = 32,
  parameter int unsigned CW = 7
) (
  input  wire logic [DW-1:0] enc_data_i,
  output logic      [CW-1:0] enc_check_o,
  input  wire logic [DW-1:0] dec_data_i,
  input  wire logic [CW-1:0] dec_check_i,
  output logic      [DW-1:0] dec_data_o,
  output logic               single_err_o,
  output logic               double_err_o
);

  // ******************************************************************
  // Position of data bit j in the Hamming code word, skipping powers of two
  // ******************************************************************
  function automatic logic [CW-2:0] pos_of(input int unsigned j);
    int unsigned p;
    int unsigned n;
    p = 0;
    n = 0;
    for (int unsigned k = 1; k < 64; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == j) begin
          p = k;
        end
        n++;
      end
    end
    return p[CW-2:0];
  endfunction

  // True when data bit j takes part in check bit k; a call result cannot be bit-selected.
  function automatic logic covers(input int unsigned j, input int unsigned k);
    logic [CW-2:0] p;
    p = pos_of(j);
    return p[k];
  endfunction

  logic [CW-2:0] syn;

  // Low check bits are the parities over data bits whose position holds each bit; the top one is overall parity.
  always_comb begin
    enc_check_o = '0;
    for (int unsigned j = 0; j < DW; j++) begin
      for (int unsigned k = 0; k < CW - 1; k++) begin
        if (covers(j, k)) begin
          enc_check_o[k] = enc_check_o[k] ^ enc_data_i[j];
        end
      end
    end
    enc_check_o[CW-1] = ^{enc_data_i, enc_check_o[CW-2:0]};
  end

  // Overall parity tells one flipped bit from two; only single errors are repaired.
  always_comb begin
    syn = dec_check_i[CW-2:0];
    for (int unsigned j = 0; j < DW; j++) begin
      for (int unsigned k = 0; k < CW - 1; k++) begin
        if (covers(j, k)) begin
          syn[k] = syn[k] ^ dec_data_i[j];
        end
      end
    end
    single_err_o = ^{dec_data_i, dec_check_i};
    double_err_o = !single_err_o && (syn != '0);
    dec_data_o   = dec_data_i;
    for (int unsigned j = 0; j < DW; j++) begin
      if (single_err_o && (syn == pos_of(j))) begin
        dec_data_o[j] = ~dec_data_i[j];
      end
    end
  end

endmodule

// file: rtl/fpu_exception_flags_regfile.sv
// Floating-point exception flags, trap reporting and the EDAC-protected data registers.
// Assumes the integer pipeline presents each finished operation as a one-cycle pulse
// on the core clock, and software uses a classic Wishbone master on the same clock.
//
// Behaviour
// - Overflow flags set when rounded result too large.
// - Underflow means tiny and inexact rounded result.
// - No underflow when exact result is zero.
// - Untrapped underflow sets underflow and inexact flags.
// - Tininess judged before rounding, not after.
// - Trapped underflow traps on any tiny result; the code excludes an exact zero.
// - Divide-by-zero flags for nonzero finite dividend only.
// - Inexact flags follow rounding error exactly.
// - Data registers 32 bits, EDAC, no reset.
// - Keep current and accrued flag groups.
// - Trap reports IEEE trap type one.
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module fpu_exception_flags_regfile #(
  parameter int unsigned NREGS = fpu_flags_pkg::NUM_REGS
) (
  input  wire logic                                core_clk_i,
  input  wire logic                                nrst_i,
  // Operation outcome from the pipeline.
  input  wire logic                                op_valid_i,
  input  wire fpu_flags_pkg::fpu_result_t          op_result_i,
  // Result write-back from the pipeline.
  input  wire logic                                wr_en_i,
  input  wire logic [fpu_flags_pkg::FREG_IDX_W-1:0] wr_idx_i,
  input  wire logic [fpu_flags_pkg::DATA_W-1:0]     wr_data_i,
  // Classic Wishbone slave.
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [fpu_flags_pkg::ADR_W-1:0]      adr_i,
  input  wire logic [3:0]                          sel_i,
  input  wire logic [fpu_flags_pkg::DATA_W-1:0]     dat_i,
  output logic      [fpu_flags_pkg::DATA_W-1:0]     dat_o,
  output logic                                     ack_o,
  output logic                                     err_o,
  // Trap report to the pipeline.
  output logic                                     trap_o,
  output logic      [fpu_flags_pkg::FTT_W-1:0]      ftt_o,
  output fpu_flags_pkg::fpu_flags_t                cexc_o
);

  // ******************************************************************
  // Storage
  // ******************************************************************
  logic [fpu_flags_pkg::DATA_W-1:0]  freg_mem [NREGS];
  logic [fpu_flags_pkg::CHECK_W-1:0] chk_mem  [NREGS];
  fpu_flags_pkg::fpu_flags_t         tem_q,  tem_d;
  fpu_flags_pkg::fpu_flags_t         cexc_q, cexc_d;
  fpu_flags_pkg::fpu_flags_t         aexc_q, aexc_d;
  logic [fpu_flags_pkg::FTT_W-1:0]   ftt_q,  ftt_d;
  logic                              trap_q, trap_d;
  logic [1:0]                        edac_q, edac_d;
  logic                              ack_q,  err_q;
  logic [fpu_flags_pkg::DATA_W-1:0]  dat_q,  dat_d;

  // ******************************************************************
  // Flag derivation for the operation now completing
  // ******************************************************************
  fpu_flags_pkg::fpu_flags_t raw;
  fpu_flags_pkg::fpu_flags_t trap_hit;
  wire logic ufm     = tem_q.uf;
  wire logic tiny_nz = op_result_i.tiny & ~op_result_i.exact_zero;
  wire logic uf_quiet = tiny_nz & op_result_i.inexact;
  assign raw.of = op_result_i.overflow;
  assign raw.uf = ufm ? tiny_nz : uf_quiet;
  assign raw.dz = op_result_i.divide & op_result_i.divisor_zero
                & op_result_i.dividend_nonzero;
  assign raw.nx = op_result_i.inexact | (~ufm & uf_quiet);
  // A trapped underflow needs no inexact result, so the mask bit alone decides.
  assign trap_hit = raw & tem_q;
  wire logic take_trap = op_valid_i & (trap_hit != '0);

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  wire logic [fpu_flags_pkg::FREG_IDX_W-1:0] bus_idx =
    adr_i[fpu_flags_pkg::FREG_IDX_LSB +: fpu_flags_pkg::FREG_IDX_W];
  wire logic sel_freg   = adr_i[fpu_flags_pkg::FREG_SEL_BIT];
  wire logic sel_ctrl   = adr_i == fpu_flags_pkg::CTRL_OFS;
  wire logic sel_status = adr_i == fpu_flags_pkg::STATUS_OFS;
  wire logic sel_edac   = adr_i == fpu_flags_pkg::EDAC_OFS;
  wire logic mapped     = sel_freg | sel_ctrl | sel_status | sel_edac;
  wire logic bus_req    = cyc_i & stb_i & ~ack_q & ~err_q;
  // A pipeline write owns the array this cycle, so register-file accesses wait.
  wire logic bus_go     = bus_req & ~(sel_freg & wr_en_i);
  wire logic bus_wr     = bus_go & we_i & sel_i[0];
  wire logic ctrl_wr    = bus_wr & sel_ctrl;
  wire logic status_wr  = bus_wr & sel_status;
  wire logic edac_wr    = bus_wr & sel_edac;
  wire logic freg_wr    = bus_go & we_i & sel_freg;
  wire logic freg_rd    = bus_go & ~we_i & sel_freg;

  // ******************************************************************
  // EDAC paths
  // ******************************************************************
  logic [fpu_flags_pkg::DATA_W-1:0]  rd_fixed;
  logic [fpu_flags_pkg::DATA_W-1:0]  merged;
  logic [fpu_flags_pkg::CHECK_W-1:0] bus_chk;
  logic [fpu_flags_pkg::CHECK_W-1:0] pipe_chk;
  logic                              rd_sbe;
  logic                              rd_dbe;

  // Partial writes merge new bytes into the corrected old word before encoding.
  always_comb begin
    for (int unsigned b = 0; b < 4; b++) begin
      merged[8*b +: 8] = sel_i[b] ? dat_i[8*b +: 8] : rd_fixed[8*b +: 8];
    end
  end

  // Bus side decodes the addressed word and encodes the merged write.
  edac_codec #(
    .DW (fpu_flags_pkg::DATA_W),
    .CW (fpu_flags_pkg::CHECK_W)
  ) u_bus_codec (
    .enc_data_i   (merged),
    .enc_check_o  (bus_chk),
    .dec_data_i   (freg_mem[bus_idx]),
    .dec_check_i  (chk_mem[bus_idx]),
    .dec_data_o   (rd_fixed),
    .single_err_o (rd_sbe),
    .double_err_o (rd_dbe)
  );

  // Pipeline side only encodes; its decoder inputs are idle.
  edac_codec #(
    .DW (fpu_flags_pkg::DATA_W),
    .CW (fpu_flags_pkg::CHECK_W)
  ) u_pipe_codec (
    .enc_data_i   (wr_data_i),
    .enc_check_o  (pipe_chk),
    .dec_data_i   ('0),
    .dec_check_i  ('0),
    .dec_data_o   (),
    .single_err_o (),
    .double_err_o ()
  );

  // Data registers carry no reset; an unwritten word may decode as an error.
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      freg_mem[wr_idx_i] <= wr_data_i;
      chk_mem[wr_idx_i]  <= pipe_chk;
    end else if (freg_wr) begin
      freg_mem[bus_idx] <= merged;
      chk_mem[bus_idx]  <= bus_chk;
    end
  end

  // ******************************************************************
  // Next state of flags and status
  // ******************************************************************
  wire fpu_flags_pkg::fpu_flags_t aexc_clr =
    status_wr ? dat_i[fpu_flags_pkg::AEXC_LSB +: fpu_flags_pkg::FLAG_W] : '0;
  wire logic trap_clr = status_wr & dat_i[fpu_flags_pkg::TRAP_BIT];
  wire logic [1:0] edac_set = freg_rd ? {rd_dbe, rd_sbe} : 2'h0;
  wire logic [1:0] edac_clr = edac_wr ? dat_i[1:0] : 2'h0;

  // Hardware setting wins over a software clear in the same cycle.
  always_comb begin
    tem_d  = ctrl_wr ? dat_i[fpu_flags_pkg::FLAG_W-1:0] : tem_q;
    cexc_d = op_valid_i ? raw : cexc_q;
    aexc_d = (aexc_q & ~aexc_clr)
           | ((op_valid_i && !take_trap) ? raw : '0);
    ftt_d  = take_trap ? fpu_flags_pkg::FTT_IEEE :
             (trap_clr ? fpu_flags_pkg::FTT_NONE : ftt_q);
    trap_d = take_trap;
    edac_d = (edac_q & ~edac_clr) | edac_set;
  end

  // Read data mux for the register window.
  always_comb begin
    dat_d = '0;
    if (sel_freg) begin
      dat_d = rd_fixed;
    end else if (sel_ctrl) begin
      dat_d[fpu_flags_pkg::FLAG_W-1:0] = tem_q;
    end else if (sel_status) begin
      dat_d[fpu_flags_pkg::CEXC_LSB +: fpu_flags_pkg::FLAG_W] = cexc_q;
      dat_d[fpu_flags_pkg::AEXC_LSB +: fpu_flags_pkg::FLAG_W] = aexc_q;
      dat_d[fpu_flags_pkg::TRAP_BIT] = ftt_q != fpu_flags_pkg::FTT_NONE;
      dat_d[fpu_flags_pkg::FTT_LSB +: fpu_flags_pkg::FTT_W] = ftt_q;
    end else if (sel_edac) begin
      dat_d[fpu_flags_pkg::DBE_BIT] = edac_q[1];
      dat_d[fpu_flags_pkg::SBE_BIT] = edac_q[0];
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tem_q  <= fpu_flags_pkg::TEM_RESET;
      cexc_q <= fpu_flags_pkg::FLAG_RESET;
      aexc_q <= fpu_flags_pkg::FLAG_RESET;
      ftt_q  <= fpu_flags_pkg::FTT_NONE;
      trap_q <= 1'b0;
      edac_q <= 2'h0;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      dat_q  <= '0;
    end else begin
      tem_q  <= tem_d;
      cexc_q <= cexc_d;
      aexc_q <= aexc_d;
      ftt_q  <= ftt_d;
      trap_q <= trap_d;
      edac_q <= edac_d;
      ack_q  <= bus_go & mapped;
      err_q  <= bus_go & ~mapped;
      dat_q  <= (bus_go & ~we_i) ? dat_d : dat_q;
    end
  end

  assign dat_o  = dat_q;
  assign ack_o  = ack_q;
  assign err_o  = err_q;
  assign trap_o = trap_q;
  assign ftt_o  = ftt_q;
  assign cexc_o = cexc_q;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_ovf;
    op_valid_i && op_result_i.overflow |=> cexc_q.of;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_uf_def;
    op_valid_i && !ufm && !(op_result_i.tiny && op_result_i.inexact) |=> !cexc_q.uf;
  endproperty
  a_uf_def: assert property (p_uf_def) else $error("underflow without cause");

  property p_uf_zero;
    op_valid_i && op_result_i.exact_zero |=> !cexc_q.uf;
  endproperty
  a_uf_zero: assert property (p_uf_zero) else $error("underflow on zero");

  // A trap on another enabled flag keeps the accrued group untouched.
  property p_uf_quiet;
    op_valid_i && !ufm && op_result_i.tiny && op_result_i.inexact && !op_result_i.exact_zero
      |=> cexc_q.uf && cexc_q.nx && (aexc_q.uf || trap_o);
  endproperty
  a_uf_quiet: assert property (p_uf_quiet) else $error("quiet underflow lost");

  property p_uf_trap;
    op_valid_i && ufm && tiny_nz |=> trap_o && cexc_q.uf && ftt_o == fpu_flags_pkg::FTT_IEEE;
  endproperty
  a_uf_trap: assert property (p_uf_trap) else $error("underflow trap missing");

  property p_dz;
    op_valid_i && op_result_i.divide && op_result_i.divisor_zero
      |=> cexc_q.dz == $past(op_result_i.dividend_nonzero);
  endproperty
  a_dz: assert property (p_dz) else $error("divide by zero flag wrong");

  property p_nx;
    op_valid_i && (ufm || !uf_quiet) |=> cexc_q.nx == $past(op_result_i.inexact);
  endproperty
  a_nx: assert property (p_nx) else $error("inexact flag wrong");

  property p_cexc_hold;
    !op_valid_i |=> $stable(cexc_q);
  endproperty
  a_cexc_hold: assert property (p_cexc_hold) else $error("current flags moved");

  property p_accrue;
    op_valid_i && !take_trap |=> (aexc_q & cexc_q) == cexc_q;
  endproperty
  a_accrue: assert property (p_accrue) else $error("accrued flags missed");

  property p_trap_hold;
    trap_o |-> ftt_o == fpu_flags_pkg::FTT_IEEE ##1 !trap_o || ftt_o == fpu_flags_pkg::FTT_IEEE;
  endproperty
  a_trap_hold: assert property (p_trap_hold) else $error("trap type wrong");

  property p_freg_store;
    freg_wr && !wr_en_i |=> freg_mem[$past(bus_idx)] == $past(merged);
  endproperty
  a_freg_store: assert property (p_freg_store) else $error("data word not stored");

  c_ovf_trap: cover property (op_valid_i && op_result_i.overflow && tem_q.of ##1 trap_o);
  c_uf_quiet: cover property (op_valid_i && !ufm && uf_quiet ##1 cexc_q.uf);
  c_dz:       cover property (op_valid_i && raw.dz ##1 cexc_q.dz);
  c_sbe:      cover property (freg_rd && rd_sbe ##1 ack_o);

endmodule

// file: shared/fpu_flags_pkg.sv
// Constants, register map and carrier types for the floating-point exception flag block.
// Assumes one 50 MHz core clock and a classic Wishbone slave port with byte addresses.
package fpu_flags_pkg;

  // ******************************************************************
  // Sizes
  // ******************************************************************
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned CHECK_W  = 7;
  localparam int unsigned ADR_W    = 8;
  localparam int unsigned FLAG_W   = 4;
  localparam int unsigned FTT_W    = 3;

  // ******************************************************************
  // Register map, byte addresses
  // ******************************************************************
  localparam logic [ADR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADR_W-1:0] STATUS_OFS  = 8'h04;
  localparam logic [ADR_W-1:0] EDAC_OFS    = 8'h08;
  localparam int unsigned      FREG_SEL_BIT = 7;
  localparam int unsigned      FREG_IDX_LSB = 2;
  localparam int unsigned      FREG_IDX_W   = 5;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int unsigned CEXC_LSB  = 0;
  localparam int unsigned AEXC_LSB  = 4;
  localparam int unsigned TRAP_BIT  = 8;
  localparam int unsigned FTT_LSB   = 9;
  localparam int unsigned SBE_BIT   = 0;
  localparam int unsigned DBE_BIT   = 1;
  localparam logic [FLAG_W-1:0] TEM_RESET  = 4'h0;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;
  localparam logic [FTT_W-1:0]  FTT_NONE   = 3'h0;
  localparam logic [FTT_W-1:0]  FTT_IEEE   = 3'h1;

  // Outcome of one floating-point operation as seen by the flag logic.
  typedef struct packed {
    logic overflow;
    logic divide;
    logic divisor_zero;
    logic dividend_nonzero;
    logic exact_zero;
    logic tiny;
    logic inexact;
  } fpu_result_t;

  // Exception flag group, same layout for current, accrued and trap mask.
  typedef struct packed {
    logic of;
    logic uf;
    logic dz;
    logic nx;
  } fpu_flags_t;

endpackage

// file: test/fpu_exception_flags_regfile_tb.sv
// Self-checking bench for the exception flags and the protected data registers.
// Assumes the pipeline model in pipeline_issue_model.sv and the shared package.
`timescale 1ns/1ps
module fpu_exception_flags_regfile_tb;
  // ******************************************************************
  // Signals and design
  // ******************************************************************
  logic                       core_clk, nrst, cyc, stb, we;
  logic [7:0]                 adr;
  logic [3:0]                 sel, mask_m, aexc_m;
  logic [31:0]                dat_w, dat_r, q;
  logic                       ack, err, trap, op_valid, wr_en, pend_m, e;
  logic [2:0]                 ftt;
  logic [4:0]                 wr_idx;
  logic [31:0]                wr_data;
  logic [31:0]                mem_m [32];
  fpu_flags_pkg::fpu_result_t op_result;
  fpu_flags_pkg::fpu_flags_t  cexc;
  int                         fail_count = 0;
  int                         comparisons = 0;
  localparam logic [3:0] MASKS [6] = '{4'h0, 4'h4, 4'h8, 4'h2, 4'h1, 4'hf};
  // Tiny inexact, tiny exact, exact zero, zero by zero, x by zero, overflow.
  localparam logic [6:0] CORNERS [6] = '{7'h03, 7'h02, 7'h07, 7'h30, 7'h38, 7'h41};

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  fpu_exception_flags_regfile dut (.core_clk_i(core_clk), .nrst_i(nrst), .op_valid_i(op_valid),
    .op_result_i(op_result), .wr_en_i(wr_en), .wr_idx_i(wr_idx), .wr_data_i(wr_data),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
    .dat_o(dat_r), .ack_o(ack), .err_o(err), .trap_o(trap), .ftt_o(ftt), .cexc_o(cexc));

  pipeline_issue_model iu (.clk_i(core_clk), .op_valid_o(op_valid), .op_result_o(op_result),
    .wr_en_o(wr_en), .wr_idx_o(wr_idx), .wr_data_o(wr_data));

  // ******************************************************************
  // Tasks and expectations
  // ******************************************************************
  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Classic single cycle; read data is taken at the edge that samples ack or err.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge core_clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    sel   <= s;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
    q = dat_r;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: bus answer never came", $time);
      conclude();
    end
  endtask

  // Flags that one outcome must raise under the present underflow trap mask.
  function automatic logic [3:0] exp_flags(input logic [6:0] r, input logic ufm);
    fpu_flags_pkg::fpu_result_t x;
    x = r;
    return {x.overflow, !x.exact_zero && x.tiny && (ufm || x.inexact),
            x.divide && x.divisor_zero && x.dividend_nonzero, x.inexact};
  endfunction

  task automatic set_mask(input logic [3:0] m);
    wb(1'b1, fpu_flags_pkg::CTRL_OFS, {28'h0, m}, 4'h1);
    mask_m = m;
    wb(1'b0, fpu_flags_pkg::CTRL_OFS, 32'h0, 4'hf);
    chk(32'(q[3:0]), 32'(m), "trap mask readback");
  endtask

  // One operation, or two back to back, then the current, accrued and trap state.
  task automatic do_op(input logic [6:0] r1, input logic [6:0] r2, input logic two);
    logic [3:0] f1, f2;
    logic       t1, t2, tr;
    f1 = exp_flags(r1, mask_m[2]);
    f2 = exp_flags(r2, mask_m[2]);
    t1 = |(f1 & mask_m);
    t2 = two && (|(f2 & mask_m));
    tr = two ? t2 : t1;
    iu.issue(r1, r2, two);
    #1;
    chk(32'(cexc), 32'(two ? f2 : f1), "current flags");
    chk(32'(trap), 32'(tr), "trap pulse");
    if (tr) begin
      chk(32'(ftt), 32'(fpu_flags_pkg::FTT_IEEE), "trap type");
    end
    // Each operation of a pair traps or accrues on its own; a trap stays pending.
    pend_m = pend_m | t1 | t2;
    aexc_m = aexc_m | (t1 ? 4'h0 : f1) | ((two && !t2) ? f2 : 4'h0);
    wb(1'b0, fpu_flags_pkg::STATUS_OFS, 32'h0, 4'hf);
    chk(32'(q[11:0]), 32'({pend_m ? fpu_flags_pkg::FTT_IEEE : fpu_flags_pkg::FTT_NONE,
        pend_m, aexc_m, two ? f2 : f1}), "status");
    if (pend_m || $urandom_range(0, 3) == 0) begin
      // The low nibble is read-only, so writing ones there must not change it.
      wb(1'b1, fpu_flags_pkg::STATUS_OFS, 32'h1ff, 4'hf);
      pend_m = 1'b0;
      aexc_m = 4'h0;
      wb(1'b0, fpu_flags_pkg::STATUS_OFS, 32'h0, 4'hf);
      chk(32'(q[11:0]), 32'({8'h0, two ? f2 : f1}), "status after clear");
    end
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, adr, sel, dat_w} = '0;
    void'($urandom(32'heb7e));
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    chk(32'({trap, ftt, cexc}), 32'h0, "outputs after reset");
    foreach (MASKS[i]) begin
      if (i < 3) begin
        wb(1'b0, 8'(4 * i), 32'h0, 4'hf);
        chk(32'(q[11:0]), 32'h0, "control reset value");
      end
    end
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(32'(e), 32'h1, "unmapped address refused");
    $display("test reset and map done");
    for (int i = 0; i < 32; i++) begin
      mem_m[i] = $urandom();
      iu.write_back(5'(i), mem_m[i]);
    end
    for (int i = 0; i < 32; i++) begin
      wb(1'b0, 8'h80 + 8'(4 * i), 32'h0, 4'hf);
      chk(q, mem_m[i], "data register readback");
    end
    wb(1'b1, 8'h8c, 32'haabbccdd, 4'h5);
    mem_m[3] = {mem_m[3][31:24], 8'hbb, mem_m[3][15:8], 8'hdd};
    wb(1'b0, 8'h8c, 32'h0, 4'hf);
    chk(q, mem_m[3], "byte lane merge");
    wb(1'b0, fpu_flags_pkg::EDAC_OFS, 32'h0, 4'hf);
    chk(32'(q[1:0]), 32'h0, "no error on written registers");
    $display("test data registers done");
    aexc_m = 4'h0;
    pend_m = 1'b0;
    foreach (MASKS[m]) begin
      set_mask(MASKS[m]);
      foreach (CORNERS[c]) do_op(CORNERS[c], 7'h0, 1'b0);
      repeat (6) do_op(7'($urandom()), 7'h0, 1'b0);
    end
    set_mask(4'h0);
    do_op(7'h03, 7'h38, 1'b1);
    repeat (8) begin
      set_mask(4'($urandom()));
      do_op(7'($urandom()), 7'($urandom()), 1'b1);
    end
    $display("test flags and traps done");
    conclude();
  end
endmodule

// file: test/pipeline_issue_model.sv
// Model of the integer unit that issues floating-point operations and result write-backs.
// Assumes the bench calls its tasks from one process, one request at a time.
`timescale 1ns/1ps
module pipeline_issue_model (
  input  wire logic                             clk_i,
  output logic                                  op_valid_o,
  output fpu_flags_pkg::fpu_result_t            op_result_o,
  output logic                                  wr_en_o,
  output logic [fpu_flags_pkg::FREG_IDX_W-1:0]  wr_idx_o,
  output logic [fpu_flags_pkg::DATA_W-1:0]      wr_data_o
);
  // Idle values at time zero.
  initial begin
    op_valid_o  = 1'b0;
    op_result_o = '0;
    wr_en_o     = 1'b0;
    wr_idx_o    = '0;
    wr_data_o   = '0;
  end

  // One or two operations back to back; the outcome is inverted once valid drops,
  // so a design that samples it without valid sees garbage.
  task automatic issue(input fpu_flags_pkg::fpu_result_t r1,
                       input fpu_flags_pkg::fpu_result_t r2, input logic two);
    @(posedge clk_i);
    op_valid_o  <= 1'b1;
    op_result_o <= r1;
    if (two) begin
      @(posedge clk_i);
      op_result_o <= r2;
    end
    @(posedge clk_i);
    op_valid_o  <= 1'b0;
    op_result_o <= ~(two ? r2 : r1);
  endtask

  // Result write-back; the bench writes every register before any read of it.
  task automatic write_back(input logic [4:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    wr_en_o   <= 1'b1;
    wr_idx_o  <= idx;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_en_o   <= 1'b0;
    wr_idx_o  <= ~idx;
    wr_data_o <= ~d;
  endtask
endmodule
